// [src/strap_latch_pkg.sv]
/*
 * constants, field layout and carrier types for the strap option latch.
 * assumes one 20 mhz clock and an apb master that holds each request until
 * pready is sampled high.
 */
// How it works
// [R01] straps are sampled as chip reset releases and used from then on.
// [R02] low three management address bits come from straps; pulls give one.
// [R03] management address bits four and three are fixed at zero.
// [R04] address zero is broadcast unless strap high or bit 9 of 16h set.
// [R05] mode field: 000 normal, 110 back-to-back, others reserved and unused.
// [R06] isolate strap loads control register 0h bit 10; high enables isolate.
// [R07] speed strap loads 0h bit 13; high means 100 mbps, low 10 mbps.
// [R08] speed strap also sets the advertised speed capability in register 4h.
// [R09] duplex strap loads 0h bit 8; high half duplex, low full duplex.
// [R10] autoneg strap loads 0h bit 12; high enables auto-negotiation.
// [R11] test tree mode is entered only when its strap is sampled low.
// [R12] broadcast-disable strap is held; high makes address zero unique.
// [R13] shared pins stay inputs during reset, then switch to output function.
// [R14] captured strap values stay fixed until the next chip reset.
`default_nettype none
package strap_latch_pkg;
    // strap pin positions in the shared pin vector
    localparam int PIN_ADDR0 = 0;
    localparam int PIN_ADDR2 = 2;
    localparam int PIN_CFG0 = 3;
    localparam int PIN_CFG2 = 5;
    localparam int PIN_ISO = 6;
    localparam int PIN_SPEED = 7;
    localparam int PIN_DUPLEX = 8;
    localparam int PIN_AUTONEG = 9;
    localparam int PIN_BCAST = 10;
    localparam int PIN_NAND = 11;
    localparam int NUM_PINS = 12;
    // internal pull levels: addr0, speed, duplex, autoneg, nand pulled up
    localparam logic [11:0] STRAP_DEFAULT = 12'hb81;

    // register indices as printed, byte address is four times the index
    localparam logic [7:0] BASIC_CTRL_IDX = 8'h00;
    localparam logic [7:0] ADV_IDX = 8'h04;
    localparam logic [7:0] PHY_CTRL_IDX = 8'h16;
    localparam logic [7:0] STRAP_STAT_IDX = 8'h20;

    // field positions
    localparam int BC_SPEED = 13;
    localparam int BC_AUTONEG = 12;
    localparam int BC_ISOLATE = 10;
    localparam int BC_DUPLEX = 8;
    localparam int PC_BCAST_OFF = 9;
    localparam logic [15:0] BC_MASK = 16'h3500;
    localparam logic [15:0] ADV_MASK = 16'h01e0;
    localparam logic [15:0] PC_MASK = 16'h0200;
    localparam logic [15:0] ADV_SELECTOR = 16'h0001;
    localparam logic [15:0] ADV_CAP_100 = 16'h0180;
    localparam logic [15:0] ADV_CAP_10 = 16'h0060;

    // values after reset
    localparam logic [15:0] BASIC_CTRL_RST = 16'h3100;
    localparam logic [15:0] ADV_RST = 16'h01e1;
    localparam logic [15:0] PHY_CTRL_RST = 16'h0000;
    localparam logic [1:0] MGMT_ADDR_HI = 2'h0;

    // synchroniser depth before the capture edge
    localparam logic [1:0] SETTLE_CYCLES = 2'h2;

    typedef enum logic [2:0] {
        MODE_MII = 3'h0,
        MODE_B2B = 3'h6
    } host_mode_t;

    typedef enum logic [1:0] {
        ST_SETTLE = 2'b01,
        ST_RUN = 2'b10
    } fsm_t;

    typedef struct packed {
        logic straps_valid;
        logic [4:0] mgmt_addr;
        logic addr0_bcast;
        logic [2:0] host_mode;
        logic host_mode_ok;
        logic isolate;
        logic speed_100;
        logic duplex_full;
        logic autoneg_en;
        logic nand_tree_en;
    } cfg_t;

    typedef struct packed {
        fsm_t fsm;
        logic [1:0] settle_cnt;
        logic [11:0] sync1;
        logic [11:0] sync2;
        logic [11:0] strap_lat;
        logic [15:0] basic_ctrl;
        logic [15:0] adv;
        logic [15:0] phy_ctrl;
        logic [31:0] prdata;
    } state_t;
endpackage : strap_latch_pkg
`default_nettype wire

// [src/phy_strap_option_latch.sv]
/*
 * strap option latch: captures board strap levels after chip reset,
 * holds them as the power-on configuration and exposes the settings
 * registers over apb.
 * assumes strap pins are asynchronous to clk, the apb master is on clk,
 * and the core drives func_out on clk.
 */
// Design decisions made here: the APB slave port and the address map.
`default_nettype none
module phy_strap_option_latch #(
    parameter int ADDR_W = 8
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [strap_latch_pkg::NUM_PINS-1:0] strap_pin_in,
    output logic [strap_latch_pkg::NUM_PINS-1:0] pin_out,
    output logic [strap_latch_pkg::NUM_PINS-1:0] pin_oe_n,
    input wire logic [strap_latch_pkg::NUM_PINS-1:0] func_out,
    input wire logic [4:0] frame_addr,
    output logic addr_hit,
    output strap_latch_pkg::cfg_t cfg
);
    import strap_latch_pkg::*;

    initial begin
        if (ADDR_W < 8) begin
            $error("ADDR_W must be at least 8");
        end
    end

    state_t s_r;
    state_t s_nxt;

    logic capture_now;
    logic [7:0] word_idx;
    logic [ADDR_W+1:0] paddr_ext;
    logic idx_ok;
    logic mapped;
    logic high_zero;
    logic [31:0] rd_word;
    logic [11:0] st;
    logic addr0_bcast;

    // merge a write under byte enables, only the writable bits change
    function automatic logic [15:0] merge16(
        input logic [15:0] old,
        input logic [31:0] wdata,
        input logic [3:0] strb,
        input logic [15:0] mask
    );
        logic [15:0] m;
        m = mask & {{8{strb[1]}}, {8{strb[0]}}};
        merge16 = (old & ~m) | (wdata[15:0] & m);
    endfunction : merge16

    // advertisement follows the speed strap
    function automatic logic [15:0] adv_from_speed(input logic speed);
        adv_from_speed = speed ? (ADV_SELECTOR | ADV_CAP_100 | ADV_CAP_10)
                               : (ADV_SELECTOR | ADV_CAP_10);
    endfunction : adv_from_speed

    assign st = s_r.strap_lat;
    assign capture_now = (s_r.fsm == ST_SETTLE)
                       && (s_r.settle_cnt == SETTLE_CYCLES);
    // pad the bus address so the index field exists for the narrowest bus
    assign paddr_ext = {2'b00, paddr};
    assign word_idx = paddr_ext[9:2];

    // address decode
    always_comb begin
        high_zero = 1'b1;
        for (int i = 10; i < ADDR_W; i++) begin
            if (paddr[i]) begin
                high_zero = 1'b0;
            end
        end
        idx_ok = (paddr[1:0] == 2'h0) && high_zero;
        mapped = 1'b0;
        rd_word = 32'h0000_0000;
        if (!idx_ok) begin
            mapped = 1'b0;
        end else if (word_idx == BASIC_CTRL_IDX) begin
            mapped = 1'b1;
            rd_word = {16'h0000, s_r.basic_ctrl};
        end else if (word_idx == ADV_IDX) begin
            mapped = 1'b1;
            rd_word = {16'h0000, s_r.adv};
        end else if (word_idx == PHY_CTRL_IDX) begin
            mapped = 1'b1;
            rd_word = {16'h0000, s_r.phy_ctrl};
        end else if (word_idx == STRAP_STAT_IDX) begin
            mapped = 1'b1;
            rd_word = {15'h0000, (s_r.fsm == ST_RUN), 4'h0, s_r.strap_lat};
        end
    end

    always_comb begin
        s_nxt = s_r;
        // two-flop synchroniser on the strap pins
        s_nxt.sync1 = strap_pin_in;
        s_nxt.sync2 = s_r.sync1;
        case (s_r.fsm)
            ST_SETTLE: begin
                if (capture_now) begin
                    // first synchronised sample after release is the strap
                    s_nxt.strap_lat = s_r.sync2; // see [R01]
                    s_nxt.basic_ctrl = PHY_CTRL_RST;
                    s_nxt.basic_ctrl[BC_ISOLATE] = s_r.sync2[PIN_ISO]; // see [R06]
                    s_nxt.basic_ctrl[BC_SPEED] = s_r.sync2[PIN_SPEED]; // see [R07]
                    s_nxt.basic_ctrl[BC_DUPLEX] = s_r.sync2[PIN_DUPLEX]; // see [R09]
                    s_nxt.basic_ctrl[BC_AUTONEG] =
                        s_r.sync2[PIN_AUTONEG]; // see [R10]
                    s_nxt.adv = adv_from_speed(s_r.sync2[PIN_SPEED]); // see [R08]
                    s_nxt.fsm = ST_RUN;
                end else begin
                    s_nxt.settle_cnt = s_r.settle_cnt + 2'h1;
                end
            end
            ST_RUN: begin
                // straps frozen until the next reset
                s_nxt.strap_lat = s_r.strap_lat; // see [R14]
            end
            default: begin
                s_nxt.fsm = ST_SETTLE;
                s_nxt.settle_cnt = 2'h0;
            end
        endcase
        // writes take effect at the access edge; capture has priority
        if (psel && penable && pwrite && mapped && !capture_now) begin
            if (word_idx == BASIC_CTRL_IDX) begin
                s_nxt.basic_ctrl = merge16(s_r.basic_ctrl, pwdata, pstrb,
                                           BC_MASK);
            end else if (word_idx == ADV_IDX) begin
                s_nxt.adv = merge16(s_r.adv, pwdata, pstrb, ADV_MASK);
            end else if (word_idx == PHY_CTRL_IDX) begin
                s_nxt.phy_ctrl = merge16(s_r.phy_ctrl, pwdata, pstrb,
                                         PC_MASK); // see [R04]
            end
        end
        // read data registered in the setup cycle
        if (psel && !penable) begin
            s_nxt.prdata = rd_word;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_r.fsm <= ST_SETTLE;
            s_r.settle_cnt <= 2'h0;
            s_r.sync1 <= STRAP_DEFAULT;
            s_r.sync2 <= STRAP_DEFAULT;
            s_r.strap_lat <= STRAP_DEFAULT;
            s_r.basic_ctrl <= BASIC_CTRL_RST;
            s_r.adv <= ADV_RST;
            s_r.phy_ctrl <= PHY_CTRL_RST;
            s_r.prdata <= 32'h0000_0000;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign prdata = s_r.prdata;
    assign pready = penable;
    assign pslverr = psel && penable && !mapped;

    // broadcast for address zero unless strap or software turns it off
    assign addr0_bcast = !st[PIN_BCAST]
                       && !s_r.phy_ctrl[PC_BCAST_OFF]; // see [R04] [R12]

    always_comb begin
        cfg.straps_valid = (s_r.fsm == ST_RUN);
        cfg.mgmt_addr = {MGMT_ADDR_HI, st[PIN_ADDR2:PIN_ADDR0]}; // see [R02] [R03]
        cfg.addr0_bcast = addr0_bcast;
        cfg.host_mode = st[PIN_CFG2:PIN_CFG0];
        cfg.host_mode_ok = (st[PIN_CFG2:PIN_CFG0] == MODE_MII)
                         || (st[PIN_CFG2:PIN_CFG0] == MODE_B2B); // see [R05]
        cfg.isolate = s_r.basic_ctrl[BC_ISOLATE];
        cfg.speed_100 = s_r.basic_ctrl[BC_SPEED];
        cfg.duplex_full = !s_r.basic_ctrl[BC_DUPLEX];
        cfg.autoneg_en = s_r.basic_ctrl[BC_AUTONEG];
        cfg.nand_tree_en = (s_r.fsm == ST_RUN) && !st[PIN_NAND]; // see [R11]
    end

    assign addr_hit = (frame_addr == cfg.mgmt_addr)
                    || ((frame_addr == 5'h00) && addr0_bcast); // see [R04]

    // pins stay inputs until the straps are held, then normal output
    always_comb begin
        pin_out = '0;
        pin_oe_n = '1;
        if (s_r.fsm == ST_RUN) begin
            pin_out = func_out; // see [R13]
            pin_oe_n = '0;
            // interrupt pin is open drain: drive only the low level
            pin_out[PIN_NAND] = 1'b0;
            pin_oe_n[PIN_NAND] = func_out[PIN_NAND];
        end
    end
endmodule : phy_strap_option_latch
`default_nettype wire

// [dv/strap_board.sv]
/*
 * board strap resistors beside the strap option latch.
 * assumes pin_oe_n low means the chip drives the pin.
 */
`default_nettype none
module strap_board (
    input wire logic [11:0] strap_val,
    input wire logic [11:0] pin_out,
    input wire logic [11:0] pin_oe_n,
    output logic [11:0] pin_lvl
);
    timeunit 1ns;
    timeprecision 1ns;
    // resistors set the level until the chip drives the pin
    assign pin_lvl[10:0] = (pin_oe_n[10:0] & strap_val[10:0])
        | (~pin_oe_n[10:0] & pin_out[10:0]);
    // open drain pin only pulls low
    assign pin_lvl[11] = pin_oe_n[11] ? strap_val[11] : 1'b0;
endmodule : strap_board
`default_nettype wire

// [dv/strap_latch_asserts.sv]
/*
 * concurrent checks on the strap option latch ports.
 * assumes it is bound to the top module and straps stable over release.
 */
`default_nettype none
module strap_latch_asserts (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic [11:0] strap_pin_in,
    input wire logic [11:0] pin_out,
    input wire logic [11:0] pin_oe_n,
    input wire logic [11:0] func_out,
    input wire logic [4:0] frame_addr,
    input wire logic addr_hit,
    input wire strap_latch_pkg::cfg_t cfg
);
    import strap_latch_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    a_oe_settle: assert property (!cfg.straps_valid |->
        pin_oe_n == 12'hfff) else $error("pin driven before capture");
    a_oe_run: assert property (cfg.straps_valid |->
        pin_oe_n[10:0] == 11'h0 && pin_out[10:0] == func_out[10:0])
        else $error("pin not switched to output");
    a_addr_hi: assert property (cfg.mgmt_addr[4:3] == 2'h0)
        else $error("upper address bits not zero");
    a_cap_addr: assert property ($rose(cfg.straps_valid) |->
        cfg.mgmt_addr[2:0] == $past(strap_pin_in[2:0], 2)
        && cfg.host_mode == $past(strap_pin_in[5:3], 2))
        else $error("address or mode not captured");
    a_cap_ctrl: assert property ($rose(cfg.straps_valid) |->
        cfg.isolate == $past(strap_pin_in[6], 2)
        && cfg.speed_100 == $past(strap_pin_in[7], 2)
        && cfg.duplex_full == !$past(strap_pin_in[8], 2)
        && cfg.autoneg_en == $past(strap_pin_in[9], 2))
        else $error("control straps not captured");
    a_cap_nand: assert property ($rose(cfg.straps_valid) |->
        cfg.nand_tree_en == !$past(strap_pin_in[11], 2))
        else $error("test tree strap wrong");
    a_cfg_hold: assert property (cfg.straps_valid &&
        $past(cfg.straps_valid) |-> $stable(cfg.mgmt_addr)
        && $stable(cfg.host_mode) && $stable(cfg.nand_tree_en))
        else $error("captured value changed");
    a_mode_ok: assert property (cfg.host_mode_ok ==
        (cfg.host_mode == 3'h0 || cfg.host_mode == 3'h6))
        else $error("mode legality wrong");
    a_addr_hit: assert property (addr_hit ==
        (frame_addr == cfg.mgmt_addr || (frame_addr == 5'h0
        && cfg.addr0_bcast))) else $error("address match wrong");
    a_apb_ready: assert property (psel && penable |-> pready)
        else $error("no ready in access phase");
endmodule : strap_latch_asserts
`default_nettype wire

// [dv/testbench.sv]
/*
 * testbench: strap sets, reset, capture, apb reads and writes.
 * assumes strap_board as the board and strap_latch_asserts bound in.
 */
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import strap_latch_pkg::*;
    logic clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, pready, pslverr, addr_hit, er;
    logic [7:0] paddr = 8'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd, rng = 32'hfa480fbd;
    logic [11:0] pin_lvl, pin_out, pin_oe_n, s, strap_val = STRAP_DEFAULT;
    logic [11:0] func_out = 12'h0;
    logic [4:0] frame_addr = 5'h0;
    cfg_t cfg;
    int bad_count = 0, samples_checked = 0;
    always #25 clk = ~clk;
    phy_strap_option_latch u_phy_strap_option_latch (.clk(clk),
        .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .strap_pin_in(pin_lvl),
        .pin_out(pin_out), .pin_oe_n(pin_oe_n), .func_out(func_out),
        .frame_addr(frame_addr), .addr_hit(addr_hit), .cfg(cfg));
    strap_board u_strap_board (.strap_val(strap_val), .pin_out(pin_out),
        .pin_oe_n(pin_oe_n), .pin_lvl(pin_lvl));
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs
    function automatic cfg_t exp_cfg(input logic [11:0] v, input logic ok);
        return '{ok, {2'h0, v[2:0]}, ~v[10], v[5:3],
            v[5:3] == 3'h0 || v[5:3] == 3'h6, v[6], v[7], ~v[8], v[9],
            ok & ~v[11]};
    endfunction : exp_cfg
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a,
            input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic results();
        $display("checked %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : results
    initial begin
        for (int n = 0; n < 12; n++) begin
            rng = xs(rng);
            s = n == 0 ? STRAP_DEFAULT : n == 1 ? 12'h000 :
                n == 2 ? 12'hfff : n == 3 ? 12'h030 : rng[11:0];
            @(posedge clk);
            strap_val <= s;
            frame_addr <= rng[28:24];
            arst_n <= 1'b0;
            repeat (20) @(posedge clk);
            chk(32'(cfg), 32'(exp_cfg(STRAP_DEFAULT, 1'b0)));
            arst_n <= 1'b1;
            for (int i = 0; i < 10 && cfg.straps_valid !== 1'b1; i++)
                @(posedge clk);
            @(posedge clk);
            chk(32'(cfg), 32'(exp_cfg(s, 1'b1)));
            chk(32'(pin_oe_n), 32'({func_out[11], 11'h0}));
            apb(1'b0, 8'h00, 32'h0);
            chk(rd, {18'h0, s[7], s[9], 1'b0, s[6], 1'b0, s[8], 8'h0});
            apb(1'b0, 8'h10, 32'h0);
            chk(rd, s[7] ? 32'h1e1 : 32'h61);
            apb(1'b0, 8'h80, 32'h0);
            chk(rd, {15'h0, 1'b1, 4'h0, s});
            apb(1'b0, 8'h44, 32'h0);
            chk({rd[30:0], er}, 32'h1);
            frame_addr <= 5'h0;
            strap_val <= ~s;
            func_out <= rng[23:12];
            repeat (4) @(posedge clk);
            chk(32'(cfg), 32'(exp_cfg(s, 1'b1)));
            chk(32'(addr_hit), 32'(s[2:0] == 3'h0 || !s[10]));
            apb(1'b1, 8'h58, 32'h200);
            apb(1'b0, 8'h58, 32'h0);
            chk(rd, 32'h200);
            chk(32'(addr_hit), 32'(s[2:0] == 3'h0));
        end
        results();
    end
    initial begin
        #200000;
        bad_count++;
        results();
    end
endmodule : testbench
bind phy_strap_option_latch strap_latch_asserts u_strap_latch_asserts (
    .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pready(pready), .strap_pin_in(strap_pin_in), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .func_out(func_out), .frame_addr(frame_addr),
    .addr_hit(addr_hit), .cfg(cfg));
`default_nettype wire
